// file: logic/paged_regs_pkg.sv
// constants for the paged device control register bank
package paged_regs_pkg;

    // register geometry
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned PAGE_LOCS = 128;
    localparam logic [7:0] PAGE_ZERO = 8'h00;

    // page-zero offsets
    localparam logic [6:0] OFS_PAGE_SELECT = 7'h00;
    localparam logic [6:0] OFS_SOFT_RESET = 7'h01;
    localparam logic [6:0] OFS_GENERAL_SETUP = 7'h02;
    localparam logic [6:0] OFS_CTRL_CLOCK_5 = 7'h3A;
    localparam logic [6:0] OFS_CTRL_CLOCK_6 = 7'h3B;
    localparam logic [6:0] OFS_CLOCK_FAULT_0 = 7'h3C;
    localparam logic [6:0] OFS_RATIO_DETECT_3 = 7'h41;
    localparam logic [6:0] OFS_INTERRUPT_SETUP = 7'h42;
    localparam logic [6:0] OFS_OVERLOAD_SETUP = 7'h4B;
    localparam logic [6:0] OFS_CURRENT_CONV = 7'h4C;
    localparam logic [6:0] OFS_REF_BIAS = 7'h4D;
    localparam logic [6:0] OFS_POWER_TUNING = 7'h4E;
    localparam logic [6:0] OFS_CONV1_A = 7'h50;
    localparam logic [6:0] OFS_CURRENT_CHAN = 7'h51;
    localparam logic [6:0] OFS_CONV1_C = 7'h52;
    localparam logic [6:0] OFS_CONV1_D = 7'h53;
    localparam logic [6:0] OFS_CONV1_E = 7'h54;
    localparam logic [6:0] OFS_CONV2_A = 7'h55;
    localparam logic [6:0] OFS_CONV2_C = 7'h57;
    localparam logic [6:0] OFS_CONV2_D = 7'h58;
    localparam logic [6:0] OFS_CONV2_E = 7'h59;
    localparam logic [6:0] OFS_CONV3_A = 7'h5A;
    localparam logic [6:0] OFS_CONV3_C = 7'h5B;
    localparam logic [6:0] OFS_CONV3_D = 7'h5C;
    localparam logic [6:0] OFS_CONV3_E = 7'h5D;
    localparam logic [6:0] OFS_CONV4_A = 7'h5E;
    localparam logic [6:0] OFS_CONV4_C = 7'h5F;
    localparam logic [6:0] OFS_CONV4_D = 7'h60;
    localparam logic [6:0] OFS_CONV4_E = 7'h61;
    localparam logic [6:0] OFS_CONV_GLOBAL = 7'h62;
    localparam logic [6:0] OFS_SIGNAL_PROC = 7'h72;
    localparam logic [6:0] OFS_CHANNEL_ENABLES = 7'h76;
    localparam logic [6:0] OFS_DYN_POWER_SEQ = 7'h77;
    localparam logic [6:0] OFS_POWER_UP_SETUP = 7'h78;
    localparam logic [6:0] OFS_DEVICE_STATE_0 = 7'h79;
    localparam logic [6:0] OFS_DEVICE_STATE_1 = 7'h7A;
    localparam logic [6:0] OFS_PORT_CHECKSUM = 7'h7E;

    // reset values: the zero default and those that differ from it
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_CURRENT_CONV = 8'h5C;
    localparam logic [7:0] RST_CONV_SETUP_C = 8'hA1;
    localparam logic [7:0] RST_CONV_SETUP_D = 8'h80;
    localparam logic [7:0] RST_SIGNAL_PROC = 8'h18;
    localparam logic [7:0] RST_CHANNEL_ENABLES = 8'hCC;
    localparam logic [7:0] RST_DEVICE_STATE_1 = 8'h80;

    // writable masks and field positions
    localparam logic [7:0] MASK_ALL = 8'hFF;
    localparam logic [7:0] MASK_SOFT_RESET = 8'h01;
    localparam logic [7:0] MASK_GENERAL_SETUP = 8'h3F;
    localparam int unsigned BIT_SOFT_RESET = 0;
    localparam int unsigned BIT_ACTIVE = 0;
    localparam int unsigned BIT_IO_RANGE = 1;
    localparam int unsigned BIT_ANALOG_SEL = 2;
    localparam int unsigned BIT_EXIT_BIAS = 3;
    localparam int unsigned BIT_PRECHARGE_LO = 4;
    localparam int unsigned BIT_STATE_AWAKE = 7;
    localparam int unsigned BIT_STATE_CHARGING = 6;

    // precharge times in microseconds and derived cycle counts
    localparam int unsigned CLK_KHZ = 10000;
    localparam int unsigned PRECHARGE_0_US = 3500;
    localparam int unsigned PRECHARGE_1_US = 10000;
    localparam int unsigned PRECHARGE_2_US = 50000;
    localparam int unsigned PRECHARGE_3_US = 100000;
    localparam int unsigned PRECHARGE_0_CYC = (PRECHARGE_0_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned PRECHARGE_1_CYC = (PRECHARGE_1_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned PRECHARGE_2_CYC = (PRECHARGE_2_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned PRECHARGE_3_CYC = (PRECHARGE_3_US * CLK_KHZ + 999) / 1000;
    localparam int unsigned CNT_W = 20;

endpackage : paged_regs_pkg

// file: logic/paged_device_control_regs.sv
// paged control register bank with sleep, supply and precharge control
`timescale 1ns/10ps
`default_nettype none

module paged_device_control_regs #(
    parameter int unsigned P_PRECHARGE_0_CYC = paged_regs_pkg::PRECHARGE_0_CYC,
    parameter int unsigned P_PRECHARGE_1_CYC = paged_regs_pkg::PRECHARGE_1_CYC,
    parameter int unsigned P_PRECHARGE_2_CYC = paged_regs_pkg::PRECHARGE_2_CYC,
    parameter int unsigned P_PRECHARGE_3_CYC = paged_regs_pkg::PRECHARGE_3_CYC
) (
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic       i_wr_en,
    input  wire logic       i_rd_en,
    input  wire logic [6:0] i_addr,
    input  wire logic [7:0] i_wdata,
    output logic      [7:0] o_rdata,
    output logic            o_rd_valid,
    output logic      [7:0] o_page,
    output logic            o_active_not_sleep,
    output logic            o_digital_regulator_on,
    output logic            o_bias_on,
    output logic            o_precharge_busy,
    output logic      [1:0] o_reference_precharge_time,
    output logic            o_analog_supply_select,
    output logic            o_io_supply_range
);

    typedef logic [127:0][7:0] regfile_t;

    typedef struct packed {
        regfile_t   regs;
        logic [7:0] page;
        logic [7:0] rdata;
        logic       rd_valid;
        logic       bias_on;
        logic       busy;
        logic [19:0] cnt;
    } state_t;

    // reset value of each page-zero location
    function automatic logic [7:0] default_of(input logic [6:0] a);
        logic [7:0] v;
        v = paged_regs_pkg::RST_ZERO;
        case (a)
            paged_regs_pkg::OFS_CURRENT_CONV:
                v = paged_regs_pkg::RST_CURRENT_CONV;
            paged_regs_pkg::OFS_CONV1_C, paged_regs_pkg::OFS_CONV2_C,
            paged_regs_pkg::OFS_CONV3_C, paged_regs_pkg::OFS_CONV4_C:
                v = paged_regs_pkg::RST_CONV_SETUP_C;
            paged_regs_pkg::OFS_CONV1_D, paged_regs_pkg::OFS_CONV2_D,
            paged_regs_pkg::OFS_CONV3_D, paged_regs_pkg::OFS_CONV4_D:
                v = paged_regs_pkg::RST_CONV_SETUP_D;
            paged_regs_pkg::OFS_SIGNAL_PROC:
                v = paged_regs_pkg::RST_SIGNAL_PROC;
            paged_regs_pkg::OFS_CHANNEL_ENABLES:
                v = paged_regs_pkg::RST_CHANNEL_ENABLES;
            paged_regs_pkg::OFS_DEVICE_STATE_1:
                v = paged_regs_pkg::RST_DEVICE_STATE_1;
            default:
                v = paged_regs_pkg::RST_ZERO;
        endcase
        return v;
    endfunction : default_of

    // bits that a write may change; zero for read-only and unmapped
    function automatic logic [7:0] wmask_of(input logic [6:0] a);
        logic [7:0] m;
        m = 8'h00;
        case (a)
            paged_regs_pkg::OFS_SOFT_RESET:
                m = paged_regs_pkg::MASK_SOFT_RESET;
            paged_regs_pkg::OFS_GENERAL_SETUP:
                m = paged_regs_pkg::MASK_GENERAL_SETUP;
            paged_regs_pkg::OFS_CTRL_CLOCK_5, paged_regs_pkg::OFS_CTRL_CLOCK_6,
            paged_regs_pkg::OFS_INTERRUPT_SETUP,
            paged_regs_pkg::OFS_OVERLOAD_SETUP,
            paged_regs_pkg::OFS_CURRENT_CONV, paged_regs_pkg::OFS_REF_BIAS,
            paged_regs_pkg::OFS_POWER_TUNING, paged_regs_pkg::OFS_CONV1_A,
            paged_regs_pkg::OFS_CURRENT_CHAN, paged_regs_pkg::OFS_CONV1_C,
            paged_regs_pkg::OFS_CONV1_D, paged_regs_pkg::OFS_CONV1_E,
            paged_regs_pkg::OFS_CONV2_A, paged_regs_pkg::OFS_CONV2_C,
            paged_regs_pkg::OFS_CONV2_D, paged_regs_pkg::OFS_CONV2_E,
            paged_regs_pkg::OFS_CONV3_A, paged_regs_pkg::OFS_CONV3_C,
            paged_regs_pkg::OFS_CONV3_D, paged_regs_pkg::OFS_CONV3_E,
            paged_regs_pkg::OFS_CONV4_A, paged_regs_pkg::OFS_CONV4_C,
            paged_regs_pkg::OFS_CONV4_D, paged_regs_pkg::OFS_CONV4_E,
            paged_regs_pkg::OFS_CONV_GLOBAL, paged_regs_pkg::OFS_SIGNAL_PROC,
            paged_regs_pkg::OFS_CHANNEL_ENABLES,
            paged_regs_pkg::OFS_DYN_POWER_SEQ,
            paged_regs_pkg::OFS_POWER_UP_SETUP,
            paged_regs_pkg::OFS_PORT_CHECKSUM:
                m = paged_regs_pkg::MASK_ALL;
            default:
                m = 8'h00;
        endcase
        return m;
    endfunction : wmask_of

    // whether a page-zero offset exists at all; others read zero
    function automatic logic mapped(input logic [6:0] a);
        logic hit;
        hit = (wmask_of(a) != 8'h00)
            || (a == paged_regs_pkg::OFS_PAGE_SELECT)
            || (a == paged_regs_pkg::OFS_DEVICE_STATE_0)
            || (a == paged_regs_pkg::OFS_DEVICE_STATE_1)
            || ((a >= paged_regs_pkg::OFS_CLOCK_FAULT_0)
                && (a <= paged_regs_pkg::OFS_RATIO_DETECT_3));
        return hit;
    endfunction : mapped

    // whole default register file
    function automatic regfile_t defaults();
        regfile_t r;
        r = '0;
        for (int i = 0; i < paged_regs_pkg::PAGE_LOCS; i++) begin
            r[i] = default_of(7'(i));
        end
        return r;
    endfunction : defaults

    localparam regfile_t REGS_RESET = defaults();
    localparam state_t STATE_RESET = '{
        regs: REGS_RESET, page: paged_regs_pkg::PAGE_ZERO,
        rdata: 8'h00, rd_valid: 1'b0, bias_on: 1'b0, busy: 1'b0,
        cnt: 20'h00000};

    state_t     state_q;
    state_t     state_d;
    logic [7:0] setup;
    logic       on_page0;
    logic       soft_reset;
    logic [19:0] load_cnt;

    // live fields of the general setup register
    assign setup = state_q.regs[paged_regs_pkg::OFS_GENERAL_SETUP];
    assign on_page0 = (state_q.page == paged_regs_pkg::PAGE_ZERO);
    assign soft_reset = state_q.regs[paged_regs_pkg::OFS_SOFT_RESET]
                        [paged_regs_pkg::BIT_SOFT_RESET];

    // precharge length chosen by the two-bit field
    always_comb begin
        case (setup[paged_regs_pkg::BIT_PRECHARGE_LO +: 2])
            2'h0:    load_cnt = 20'(P_PRECHARGE_0_CYC - 1);
            2'h1:    load_cnt = 20'(P_PRECHARGE_1_CYC - 1);
            2'h2:    load_cnt = 20'(P_PRECHARGE_2_CYC - 1);
            2'h3:    load_cnt = 20'(P_PRECHARGE_3_CYC - 1);
            default: load_cnt = 20'(P_PRECHARGE_0_CYC - 1);
        endcase
    end

    // next state: register writes, reads, soft reset, precharge timer
    always_comb begin
        state_d = state_q;
        state_d.rd_valid = 1'b0;
        if (soft_reset) begin
            state_d = STATE_RESET;
        end else begin
            if (i_wr_en) begin
                if (i_addr == paged_regs_pkg::OFS_PAGE_SELECT) begin
                    state_d.page = i_wdata;
                end else if (on_page0) begin
                    state_d.regs[i_addr] = (state_q.regs[i_addr]
                        & ~wmask_of(i_addr))
                        | (i_wdata & wmask_of(i_addr));
                end
            end
            // bias follows wake with the exit option set
            state_d.bias_on = setup[paged_regs_pkg::BIT_ACTIVE]
                && setup[paged_regs_pkg::BIT_EXIT_BIAS];
            // precharge starts with the bias and stops in the cycle it drops
            if (!state_d.bias_on) begin
                state_d.busy = 1'b0;
                state_d.cnt = 20'h00000;
            end else if (!state_q.bias_on) begin
                state_d.busy = 1'b1;
                state_d.cnt = load_cnt;
            end else if (state_q.busy) begin
                if (state_q.cnt == 20'h00000) begin
                    state_d.busy = 1'b0;
                end else begin
                    state_d.cnt = state_q.cnt - 20'h00001;
                end
            end
        end
        // device state byte reflects wake and precharge
        state_d.regs[paged_regs_pkg::OFS_DEVICE_STATE_0]
            [paged_regs_pkg::BIT_STATE_AWAKE] =
            state_d.regs[paged_regs_pkg::OFS_GENERAL_SETUP]
            [paged_regs_pkg::BIT_ACTIVE];
        state_d.regs[paged_regs_pkg::OFS_DEVICE_STATE_0]
            [paged_regs_pkg::BIT_STATE_CHARGING] = state_d.busy;
        // read data for the selected page
        if (i_rd_en) begin
            state_d.rd_valid = 1'b1;
            if (i_addr == paged_regs_pkg::OFS_PAGE_SELECT) begin
                state_d.rdata = state_q.page;
            end else if (on_page0 && mapped(i_addr)) begin
                state_d.rdata = state_q.regs[i_addr];
            end else begin
                state_d.rdata = 8'h00;
            end
        end
    end

    // single state register, synchronous reset
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_q <= STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs straight from state flops
    assign o_rdata = state_q.rdata;
    assign o_rd_valid = state_q.rd_valid;
    assign o_page = state_q.page;
    assign o_active_not_sleep = setup[paged_regs_pkg::BIT_ACTIVE];
    assign o_digital_regulator_on = setup[paged_regs_pkg::BIT_ACTIVE];
    assign o_bias_on = state_q.bias_on;
    assign o_precharge_busy = state_q.busy;
    assign o_reference_precharge_time =
        setup[paged_regs_pkg::BIT_PRECHARGE_LO +: 2];
    assign o_analog_supply_select = setup[paged_regs_pkg::BIT_ANALOG_SEL];
    assign o_io_supply_range = setup[paged_regs_pkg::BIT_IO_RANGE];

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    // register writes, soft reset, precharge, bias, sleep after reset, reserved bits and read latency
    a_page_any_value: assert property (
        i_wr_en && i_addr == paged_regs_pkg::OFS_PAGE_SELECT && !soft_reset
        |=> o_page == $past(i_wdata))
        else $error("page register did not take written value");

    a_soft_reset_clears: assert property (
        soft_reset |=> o_page == paged_regs_pkg::PAGE_ZERO && !soft_reset
            && state_q.regs == REGS_RESET)
        else $error("soft reset did not restore defaults");

    a_precharge_length: assert property (
        $rose(o_precharge_busy) |-> state_q.cnt == $past(load_cnt))
        else $error("precharge timer loaded with wrong length");

    a_bias_needs_exit: assert property (
        o_bias_on |-> $past(setup[paged_regs_pkg::BIT_EXIT_BIAS])
            && $past(setup[paged_regs_pkg::BIT_ACTIVE]))
        else $error("bias on without exit option");

    a_sleep_after_reset: assert property (
        $rose(i_rst_n) |-> !o_active_not_sleep && !o_bias_on)
        else $error("device awake straight after reset");

    a_supply_writes: assert property (
        i_wr_en && on_page0 && !soft_reset
        && i_addr == paged_regs_pkg::OFS_GENERAL_SETUP
        |=> o_analog_supply_select == $past(i_wdata[2])
            && o_io_supply_range == $past(i_wdata[1]))
        else $error("supply selects not written");

    a_reserved_zero: assert property (
        setup[7:6] == 2'h0
        && state_q.regs[paged_regs_pkg::OFS_SOFT_RESET][7:1] == 7'h00)
        else $error("reserved bits not zero");

    a_read_latency: assert property (
        i_rd_en |=> o_rd_valid ##1 !o_rd_valid || $past(i_rd_en))
        else $error("read answer not one cycle pulse");

    a_busy_ends: assert property (
        o_precharge_busy && state_q.cnt == 20'h00000 && o_bias_on
        |=> !o_precharge_busy)
        else $error("precharge did not end at zero count");

    // reset and page behaviour
    a_reset_defaults: assert property (
        $rose(i_rst_n) |-> state_q.regs == REGS_RESET)
        else $error("registers not at defaults after reset");

    a_page_zero_start: assert property (
        $rose(i_rst_n) |-> o_page == paged_regs_pkg::PAGE_ZERO
            && !o_rd_valid && !o_precharge_busy)
        else $error("page or port not idle after reset");

    a_page_read_any: assert property (
        i_rd_en && i_addr == paged_regs_pkg::OFS_PAGE_SELECT
        |=> o_rdata == $past(o_page))
        else $error("page register not readable");

    a_off_page_read: assert property (
        i_rd_en && !on_page0 && i_addr != paged_regs_pkg::OFS_PAGE_SELECT
        |=> o_rdata == paged_regs_pkg::RST_ZERO)
        else $error("read off page zero returned data");

    // sleep, bias, supply selects and soft reset self-clear
    a_sleep_bit_write: assert property (
        i_wr_en && on_page0 && !soft_reset
        && i_addr == paged_regs_pkg::OFS_GENERAL_SETUP
        |=> o_active_not_sleep
            == $past(i_wdata[paged_regs_pkg::BIT_ACTIVE]))
        else $error("sleep control not written");

    a_exit_bias_on: assert property (
        o_active_not_sleep && setup[paged_regs_pkg::BIT_EXIT_BIAS]
        && !soft_reset |=> o_bias_on)
        else $error("bias stayed off with exit option set");

    a_supply_hold: assert property (
        !(i_wr_en && i_addr == paged_regs_pkg::OFS_GENERAL_SETUP)
        && !soft_reset
        |=> $stable(o_analog_supply_select) && $stable(o_io_supply_range))
        else $error("supply select changed without a write");

    a_soft_self_clear: assert property (
        i_wr_en && on_page0 && !soft_reset
        && i_addr == paged_regs_pkg::OFS_SOFT_RESET
        && i_wdata[paged_regs_pkg::BIT_SOFT_RESET]
        |=> soft_reset ##1 !soft_reset)
        else $error("soft reset bit did not clear itself");

    // precharge and read port
    a_busy_needs_bias: assert property (
        o_precharge_busy |-> o_bias_on)
        else $error("precharge busy without bias");

    a_rdata_holds: assert property (
        !i_rd_en && !soft_reset |=> $stable(o_rdata))
        else $error("read data changed without a read");

    a_valid_after_read: assert property (
        o_rd_valid |-> $past(i_rd_en))
        else $error("read valid without a read");

    // main scenarios
    c_page_change: cover property (
        i_wr_en && i_addr == paged_regs_pkg::OFS_PAGE_SELECT
        && i_wdata != 8'h00);
    c_soft_reset: cover property (soft_reset);
    c_precharge_done: cover property ($fell(o_precharge_busy) && o_bias_on);
    c_wake_no_bias: cover property ($rose(o_active_not_sleep)
        && !setup[paged_regs_pkg::BIT_EXIT_BIAS]);
    c_off_page_read: cover property (i_rd_en && !on_page0);

endmodule : paged_device_control_regs

`default_nettype wire

// file: tb/host_port_model.sv
// host model that drives the register port of the control bank
`timescale 1ns/10ps
`default_nettype none

module host_port_model (
    input  wire logic       i_mclk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rd_valid,
    output logic            o_wr_en,
    output logic            o_rd_en,
    output logic      [6:0] o_addr,
    output logic      [7:0] o_wdata
);
    // idle bus at time zero
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr  = 7'h00;
        o_wdata = 8'h00;
    end

    // one write strobe; reserved bits always go out as zero
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == 7'h01) ? 8'h01 : (a == 7'h02) ? 8'h3F : 8'hFF;
        @(posedge i_mclk);
        o_wr_en <= 1'b1;
        o_addr  <= a;
        o_wdata <= d & m;
        @(posedge i_mclk);
        o_wr_en <= 1'b0;
        o_addr  <= ~a; // released lines do not keep the last value
        o_wdata <= ~(d & m);
    endtask : wr

    // one read strobe, then wait a bounded time for the valid pulse
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        d = 'x;
        @(posedge i_mclk);
        o_rd_en <= 1'b1;
        o_addr  <= a;
        @(posedge i_mclk);
        o_rd_en <= 1'b0;
        o_addr  <= ~a;
        for (int i = 0; i < 4; i++) begin
            @(negedge i_mclk);
            if (i_rd_valid === 1'b1) begin
                d = i_rdata;
                break;
            end
        end
    endtask : rd
endmodule : host_port_model

`default_nettype wire

// file: tb/paged_device_control_regs_tb.sv
// self-checking bench for the paged control register bank
`timescale 1ns/10ps
`default_nettype none

module paged_device_control_regs_tb;
    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] rst;
        logic [7:0] wd;
        logic [7:0] exp;
    } row_t;

    logic       i_mclk, i_rst_n, wr_en, rd_en, rd_valid;
    logic       awake, dig_on, bias, busy, asel, iorng;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, page, rd_d, n;
    logic [1:0] prech;
    int         failures, num_checks;

    // offset, reset value, write data, value read back; mapped only
    row_t rows [14] = '{
        '{7'h02, 8'h00, 8'h36, 8'h36}, '{7'h3A, 8'h00, 8'hA5, 8'hA5},
        '{7'h3C, 8'h00, 8'hFF, 8'h00}, '{7'h41, 8'h00, 8'h5A, 8'h00},
        '{7'h4C, 8'h5C, 8'h33, 8'h33}, '{7'h52, 8'hA1, 8'h0F, 8'h0F},
        '{7'h53, 8'h80, 8'h11, 8'h11}, '{7'h5F, 8'hA1, 8'h22, 8'h22},
        '{7'h60, 8'h80, 8'h44, 8'h44}, '{7'h72, 8'h18, 8'h66, 8'h66},
        '{7'h76, 8'hCC, 8'hC3, 8'hC3}, '{7'h7A, 8'h80, 8'hFF, 8'h80},
        '{7'h7E, 8'h00, 8'h7E, 8'h7E}, '{7'h77, 8'h00, 8'h55, 8'h55}};

    host_port_model host (.i_mclk(i_mclk), .i_rdata(rdata),
        .i_rd_valid(rd_valid), .o_wr_en(wr_en), .o_rd_en(rd_en),
        .o_addr(addr), .o_wdata(wdata));

    paged_device_control_regs #(.P_PRECHARGE_0_CYC(4),
        .P_PRECHARGE_1_CYC(6), .P_PRECHARGE_2_CYC(8),
        .P_PRECHARGE_3_CYC(10)) dut (.i_mclk(i_mclk),
        .i_rst_n(i_rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en),
        .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
        .o_rd_valid(rd_valid), .o_page(page),
        .o_active_not_sleep(awake), .o_digital_regulator_on(dig_on),
        .o_bias_on(bias), .o_precharge_busy(busy),
        .o_reference_precharge_time(prech),
        .o_analog_supply_select(asel), .o_io_supply_range(iorng));

    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // verdict and end of run
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // 10 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    // watchdog well beyond the expected run
    initial begin
        #(3000 * 100);
        failures++;
        test_done();
    end

    // main sequence
    initial begin
        failures = 0;
        num_checks = 0;
        i_rst_n = 1'b0;
        repeat (20) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        chk(page, 8'h00);
        chk({4'h0, awake, dig_on, bias, busy}, 8'h00);
        foreach (rows[i]) begin
            host.rd(rows[i].addr, rd_d);
            chk(rd_d, rows[i].rst);
            host.wr(rows[i].addr, rows[i].wd);
            host.rd(rows[i].addr, rd_d);
            chk(rd_d, rows[i].exp);
        end
        chk({4'h0, prech, asel, iorng}, 8'h0F);
        chk({7'h00, awake}, 8'h00);
        // wake with regulator only
        host.wr(7'h02, 8'h01);
        repeat (3) @(negedge i_mclk);
        chk({4'h0, awake, dig_on, bias, busy}, 8'h0C);
        // every precharge code, counted in cycles of busy
        for (int c = 0; c < 4; c++) begin
            host.wr(7'h02, 8'h00);
            host.wr(7'h02, 8'h09 | (8'(c) << 4));
            n = 8'h00;
            repeat (30) begin
                @(negedge i_mclk);
                n = n + {7'h00, busy === 1'b1};
            end
            chk(n, 8'(4 + 2 * c));
        end
        chk({6'h00, bias, dig_on}, 8'h03);
        host.rd(7'h79, rd_d);
        chk(rd_d, 8'h80);
        // page change and accesses off page zero
        host.wr(7'h00, 8'hFF);
        host.rd(7'h00, rd_d);
        chk(rd_d, 8'hFF);
        chk(page, 8'hFF);
        host.wr(7'h4C, 8'h12);
        host.rd(7'h4C, rd_d);
        chk(rd_d, 8'h00);
        host.wr(7'h00, 8'h00);
        host.rd(7'h4C, rd_d);
        chk(rd_d, 8'h33);
        // software reset restores defaults and clears itself
        host.wr(7'h01, 8'h01);
        repeat (3) @(negedge i_mclk);
        host.rd(7'h01, rd_d);
        chk(rd_d, 8'h00);
        host.rd(7'h4C, rd_d);
        chk(rd_d, 8'h5C);
        host.rd(7'h02, rd_d);
        chk(rd_d, 8'h00);
        chk({7'h00, awake}, 8'h00);
        // hardware reset in mid-run
        host.wr(7'h76, 8'h00);
        host.wr(7'h00, 8'h05);
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        host.rd(7'h76, rd_d);
        chk(rd_d, 8'hCC);
        chk(page, 8'h00);
        test_done();
    end
endmodule : paged_device_control_regs_tb

`default_nettype wire
